// [design/sdl_pkg.sv]
// shared constants and types for the serial converter load path
package sdl_pkg;
  localparam int CLK_NS = 4;
  localparam int SCLK_HALF_NS = 100;
  localparam int LOAD_MIN_NS = 50;
  localparam logic [7:0] SCLK_HALF = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] LOAD_CYC = 8'((LOAD_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [4:0] BYTE_BIT = 5'h07;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // control fields
  localparam int CTRL_CHAIN = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_CLR = 2;
  localparam int CTRL_BYTE = 3;
  localparam int CTRL_NW_LSB = 4;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_EMPTY = 2;
  // device pin sample positions
  localparam int PIN_SCLK = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_CLR = 4;
  localparam int PIN_CHAIN = 5;
  // sampler preset: every pin at its idle level, so reset makes no false edge
  localparam logic [5:0] PIN_IDLE = 6'h1A;
  typedef enum logic [2:0] {
    SDL_IDLE = 3'h0,
    SDL_SETUP = 3'h1,
    SDL_HIGH = 3'h2,
    SDL_LOW = 3'h3,
    SDL_NEXT = 3'h4,
    SDL_END = 3'h5,
    SDL_LOAD = 3'h6
  } sdl_state_t;
endpackage

// [design/sdl_link_if.sv]
// serial link between host controller and converter device
`timescale 1ns/100ps
`default_nettype none
interface sdl_link_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic latch_load_strobe_n;
  logic latch_clear_n;
  logic chain_enable;
  logic sdout;
  modport host (output sclk, sync_n, sdin, latch_load_strobe_n, latch_clear_n, chain_enable,
                input sdout);
  modport dev (input sclk, sync_n, sdin, latch_load_strobe_n, latch_clear_n, chain_enable,
               output sdout);
endinterface
`default_nettype wire

// [design/sdl_fifo.sv]
// word fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sdl_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sdl_fifo_s_t;
  sdl_fifo_s_t r_reg, r_next;
  logic [W-1:0] mem [D];
  logic         full, empty;

  ////////////////////////////////////////////////////////////////////////
  // full when pointers differ only in wrap bit
  assign full = (r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
  assign empty = r_reg.wp == r_reg.rp;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[r_reg.rp[AW-1:0]];

  // pointer update
  always_comb begin
    r_next = r_reg;
    if (in_valid && !full) r_next.wp = r_reg.wp + 1'b1;
    if (out_ready && !empty) r_next.rp = r_reg.rp + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r_reg <= '0;
    else r_reg <= r_next;
  end

  // storage, no reset needed
  always_ff @(posedge pclk) begin
    if (in_valid && !full) mem[r_reg.wp[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// [design/sdl_dev.sv]
// converter end: serial input register, converter latch, chain output
`timescale 1ns/100ps
`default_nettype none
module sdl_dev (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  sdl_link_if.dev                           link,
  output logic [sdl_pkg::CODE_BITS-1:0]     dac_code,
  output logic                              dac_updated
);
  typedef struct packed {
    logic [5:0]                       s1;
    logic [5:0]                       s2;
    logic [5:0]                       s3;
    logic [5:0]                       f;
    logic [5:0]                       fp;
    logic [sdl_pkg::WORD_BITS-1:0]    sh;
    logic [4:0]                       cnt;
    logic [sdl_pkg::CODE_BITS-1:0]    latch;
    logic                             upd;
    logic                             sdo;
  } sdl_dev_s_t;
  sdl_dev_s_t r_reg, r_next;
  logic [5:0] pins;
  logic [5:0] agree;
  logic       sclk_fall;
  logic       load_fall;

  ////////////////////////////////////////////////////////////////////////
  // pins gathered for the three-stage sampler
  assign pins = {link.chain_enable, link.latch_clear_n, link.latch_load_strobe_n,
                 link.sdin, link.sync_n, link.sclk};
  assign agree = r_reg.s2 ~^ r_reg.s3;
  assign sclk_fall = r_reg.fp[sdl_pkg::PIN_SCLK] && !r_reg.f[sdl_pkg::PIN_SCLK];
  assign load_fall = r_reg.fp[sdl_pkg::PIN_LOAD] && !r_reg.f[sdl_pkg::PIN_LOAD];

  // shift, count and latch
  always_comb begin
    r_next = r_reg;
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.f = (agree & r_reg.s3) | (~agree & r_reg.f);
    r_next.fp = r_reg.f;
    r_next.upd = 1'b0;
    if (r_reg.f[sdl_pkg::PIN_SYNC]) r_next.cnt = '0;
    if (sclk_fall && !r_reg.f[sdl_pkg::PIN_SYNC]) begin
      r_next.sh = {r_reg.sh[sdl_pkg::WORD_BITS-2:0], r_reg.f[sdl_pkg::PIN_SDI]};
      r_next.cnt = r_reg.cnt + 5'h01;
      if (r_reg.cnt == sdl_pkg::LAST_BIT && !r_reg.f[sdl_pkg::PIN_LOAD]) begin
        r_next.latch = r_next.sh[sdl_pkg::CODE_BITS-1:0];
        r_next.upd = 1'b1;
      end
    end
    if (load_fall) begin
      r_next.latch = r_reg.sh[sdl_pkg::CODE_BITS-1:0];
      r_next.upd = 1'b1;
    end
    if (!r_reg.f[sdl_pkg::PIN_CLR]) begin
      r_next.latch = '0;
      r_next.upd = 1'b0;
    end
    // top bit leaves for the next device, sixteen edges late
    r_next.sdo = r_reg.f[sdl_pkg::PIN_CHAIN] & r_next.sh[sdl_pkg::WORD_BITS-1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r_reg <= '{s1: sdl_pkg::PIN_IDLE, s2: sdl_pkg::PIN_IDLE,
                             s3: sdl_pkg::PIN_IDLE, f: sdl_pkg::PIN_IDLE,
                             fp: sdl_pkg::PIN_IDLE, default: '0};
    else r_reg <= r_next;
  end

  assign link.sdout = r_reg.sdo;
  assign dac_code = r_reg.latch;
  assign dac_updated = r_reg.upd;
endmodule
`default_nettype wire

// [design/sdl_host.sv]
// host end: apb registers, word fifo, serial framer and load strobe
`timescale 1ns/100ps
`default_nettype none
module sdl_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  sdl_link_if.host         link
);
  typedef struct packed {
    sdl_pkg::sdl_state_t st;
    logic [7:0]          tmr;
    logic [4:0]          bcnt;
    logic [3:0]          wcnt;
    logic [15:0]         sh;
    logic                sclk;
    logic                sync_n;
    logic                sdo;
    logic                load_n;
    logic [31:0]         ctrl;
    logic                rdy;
    logic                err;
    logic [31:0]         rdata;
  } sdl_host_s_t;
  sdl_host_s_t r_reg, r_next;
  logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [15:0] f_out_data;
  logic        wr_data, acc, mapped;
  logic        auto_mode;
  logic [3:0]  nwords;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  assign acc = psel && penable;
  assign wr_data = pwrite && paddr == sdl_pkg::OFS_DATA;
  assign mapped = paddr == sdl_pkg::OFS_CTRL || paddr == sdl_pkg::OFS_DATA ||
                  paddr == sdl_pkg::OFS_STAT;
  assign f_in_valid = acc && r_reg.rdy && wr_data && mapped;
  assign auto_mode = r_reg.ctrl[sdl_pkg::CTRL_AUTO];
  assign nwords = r_reg.ctrl[sdl_pkg::CTRL_NW_LSB +: 4];
  assign f_out_ready = r_reg.st == sdl_pkg::SDL_IDLE || r_reg.st == sdl_pkg::SDL_NEXT;

  sdl_fifo #(
    .W (16),
    .D (sdl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (pwdata[15:0]),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // register slave and serial framer
  always_comb begin
    r_next = r_reg;
    // one wait state; a data write waits while the fifo is full
    r_next.rdy = acc && !r_reg.rdy && (!wr_data || f_in_ready);
    r_next.err = 1'b0;
    if (acc && !r_reg.rdy) begin
      r_next.err = !mapped;
      case (paddr)
        sdl_pkg::OFS_CTRL: r_next.rdata = r_reg.ctrl;
        sdl_pkg::OFS_STAT: r_next.rdata = {29'h0, !f_out_valid, !f_in_ready,
                                           r_reg.st != sdl_pkg::SDL_IDLE};
        default: r_next.rdata = 32'h0;
      endcase
    end
    if (acc && r_reg.rdy && pwrite && paddr == sdl_pkg::OFS_CTRL) begin
      r_next.ctrl = pwdata;
    end
    if (r_reg.tmr != 8'h00) r_next.tmr = r_reg.tmr - 8'h01;
    case (r_reg.st)
      sdl_pkg::SDL_IDLE: begin
        r_next.load_n = !auto_mode;
        if (f_out_valid) begin
          r_next.sh = f_out_data;
          r_next.sync_n = 1'b0;
          r_next.tmr = sdl_pkg::SCLK_HALF;
          r_next.bcnt = '0;
          r_next.wcnt = '0;
          r_next.st = sdl_pkg::SDL_SETUP;
        end
      end
      sdl_pkg::SDL_SETUP: begin
        // clock rises only after frame select has been low a half period
        if (r_reg.tmr <= 8'h01) begin
          r_next.sclk = 1'b1;
          r_next.sdo = r_reg.sh[15];
          r_next.sh = {r_reg.sh[14:0], 1'b0};
          r_next.tmr = sdl_pkg::SCLK_HALF;
          r_next.st = sdl_pkg::SDL_HIGH;
        end
      end
      sdl_pkg::SDL_HIGH: begin
        if (r_reg.tmr <= 8'h01) begin
          r_next.sclk = 1'b0;
          r_next.tmr = sdl_pkg::SCLK_HALF;
          r_next.st = sdl_pkg::SDL_LOW;
        end
      end
      sdl_pkg::SDL_LOW: begin
        if (r_reg.tmr <= 8'h01) begin
          r_next.bcnt = r_reg.bcnt + 5'h01;
          r_next.tmr = sdl_pkg::SCLK_HALF;
          if (r_reg.bcnt == sdl_pkg::LAST_BIT) begin
            r_next.wcnt = r_reg.wcnt + 4'h1;
            if (r_reg.wcnt == nwords) begin
              r_next.sync_n = 1'b1;
              r_next.st = sdl_pkg::SDL_END;
            end else begin
              r_next.st = sdl_pkg::SDL_NEXT;
            end
          end else if (r_reg.bcnt == sdl_pkg::BYTE_BIT && r_reg.ctrl[sdl_pkg::CTRL_BYTE]) begin
            r_next.st = sdl_pkg::SDL_SETUP;
          end else begin
            r_next.sclk = 1'b1;
            r_next.sdo = r_reg.sh[15];
            r_next.sh = {r_reg.sh[14:0], 1'b0};
            r_next.st = sdl_pkg::SDL_HIGH;
          end
        end
      end
      sdl_pkg::SDL_NEXT: begin
        // frame select stays low while the next word is awaited
        if (f_out_valid) begin
          r_next.sh = f_out_data;
          r_next.bcnt = '0;
          r_next.tmr = sdl_pkg::SCLK_HALF;
          r_next.st = sdl_pkg::SDL_SETUP;
        end
      end
      sdl_pkg::SDL_END: begin
        if (r_reg.tmr <= 8'h01) begin
          if (auto_mode) begin
            r_next.st = sdl_pkg::SDL_IDLE;
          end else begin
            r_next.load_n = 1'b0;
            r_next.tmr = sdl_pkg::LOAD_CYC;
            r_next.st = sdl_pkg::SDL_LOAD;
          end
        end
      end
      sdl_pkg::SDL_LOAD: begin
        if (r_reg.tmr <= 8'h01) begin
          r_next.load_n = 1'b1;
          r_next.st = sdl_pkg::SDL_IDLE;
        end
      end
      default: r_next.st = sdl_pkg::SDL_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r_reg <= '{st: sdl_pkg::SDL_IDLE, sync_n: 1'b1, load_n: 1'b1,
                             ctrl: sdl_pkg::CTRL_RST, default: '0};
    else r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign prdata = r_reg.rdata;
  assign pready = r_reg.rdy;
  assign pslverr = r_reg.err;
  assign link.sclk = r_reg.sclk;
  assign link.sync_n = r_reg.sync_n;
  assign link.sdin = r_reg.sdo;
  assign link.latch_load_strobe_n = r_reg.load_n;
  assign link.latch_clear_n = !r_reg.ctrl[sdl_pkg::CTRL_CLR];
  assign link.chain_enable = r_reg.ctrl[sdl_pkg::CTRL_CHAIN];
endmodule
`default_nettype wire

// [bench/sdl_link_props.sv]
// property checker for the serial load link
`timescale 1ns/100ps
`default_nettype none
module sdl_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic latch_load_strobe_n,
  input wire logic chain_enable,
  input wire logic sdout
);
  logic [8:0] falls_reg;
  logic [7:0] low_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////////////////
  // falling clock edges per frame and strobe low time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      falls_reg <= 9'h000;
      low_reg <= 8'h00;
    end else begin
      if (sync_n) falls_reg <= 9'h000;
      else if ($fell(sclk)) falls_reg <= falls_reg + 9'h001;
      if (latch_load_strobe_n) low_reg <= 8'h00;
      else if (low_reg != 8'hFF) low_reg <= low_reg + 8'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // frame opening and clock high phase
  sequence s_quiet_clk;
    (!sclk) [*8];
  endsequence
  sequence s_high_half;
    sclk [*8];
  endsequence
  chk_clk_framed: assert property (sync_n |-> !sclk)
    else $error("serial clock high outside a frame");
  chk_frame_open: assert property ($fell(sync_n) |-> s_quiet_clk)
    else $error("clock edge too soon after frame start");
  chk_half_high: assert property ($rose(sclk) |-> s_high_half)
    else $error("serial clock high phase too short");
  property p_data_on_rise;
    !sync_n && !$past(sync_n) && $changed(sdin) |-> $rose(sclk);
  endproperty
  property p_frame_count;
    $rose(sync_n) |-> falls_reg != 9'h000 && falls_reg[3:0] == 4'h0;
  endproperty
  property p_strobe_width;
    $rose(latch_load_strobe_n) |-> low_reg == sdl_pkg::LOAD_CYC;
  endproperty
  property p_strobe_idle;
    $fell(latch_load_strobe_n) |-> sync_n && $past(sync_n, 20);
  endproperty
  chk_data_on_rise: assert property (p_data_on_rise)
    else $error("serial data moved away from a rising clock");
  chk_frame_count: assert property (p_frame_count)
    else $error("frame is not a whole number of words");
  chk_strobe_width: assert property (p_strobe_width)
    else $error("load strobe low time wrong");
  chk_strobe_idle: assert property (p_strobe_idle)
    else $error("load strobe inside a frame");
  chk_chain_quiet: assert property ((!chain_enable) [*8] |-> !sdout)
    else $error("chain output active with chain off");
endmodule
`default_nettype wire

// [bench/serial_dac_load_daisy_chain_test.sv]
// self-checking bench joining host end and converter end
`timescale 1ns/100ps
`default_nettype none
module serial_dac_load_daisy_chain_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, dac_updated;
  logic [11:0] dac_code;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n;
  sdl_link_if link ();
  sdl_host i_sdl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  sdl_dev i_sdl_dev (.pclk(pclk), .presetn(presetn), .link(link), .dac_code(dac_code),
    .dac_updated(dac_updated));
  sdl_link_props i_sdl_link_props (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
    .sync_n(link.sync_n), .sdin(link.sdin), .latch_load_strobe_n(link.latch_load_strobe_n),
    .chain_enable(link.chain_enable), .sdout(link.sdout));
  // clock and hang guard
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // compare, verdict, bus cycle, load wait
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_upd();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (dac_updated !== 1'b1 && n < 4000);
    check("update pulse", 32'(dac_updated), 32'h1);
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sdl_pkg::OFS_CTRL, 32'h0);
    check("ctrl reset", rd, sdl_pkg::CTRL_RST);
    apb(1'b0, sdl_pkg::OFS_STAT, 32'h0);
    check("stat reset", rd, 32'h0000_0004);
    apb(1'b1, 8'hFC, 32'h0000_000F);
    check("unmapped write", {31'h0, err}, 32'h1);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped read", {rd[30:0], err}, 32'h1);
    // manual strobe load, upper bits dropped
    apb(1'b1, sdl_pkg::OFS_DATA, 32'hFFFF_ABCD);
    @(posedge link.sync_n);
    check("no load before strobe", 32'(dac_code), 32'h0);
    wait_upd();
    check("manual load", 32'(dac_code), 32'hBCD);
    // byte-split framing
    apb(1'b1, sdl_pkg::OFS_CTRL, 32'h0000_0008);
    apb(1'b1, sdl_pkg::OFS_DATA, 32'h0000_0123);
    wait_upd();
    check("byte mode load", 32'(dac_code), 32'h123);
    // clear forces zero
    apb(1'b1, sdl_pkg::OFS_CTRL, 32'h0000_0004);
    repeat (20) @(posedge pclk);
    check("clear", 32'(dac_code), 32'h0);
    // two-word chain frame, last word stays
    apb(1'b1, sdl_pkg::OFS_CTRL, 32'h0000_0011);
    apb(1'b1, sdl_pkg::OFS_DATA, 32'h0000_1AAA);
    apb(1'b1, sdl_pkg::OFS_DATA, 32'h0000_A555);
    wait_upd();
    check("chain load", 32'(dac_code), 32'h555);
    check("chain output", 32'(link.sdout), 32'h1);
    // fill buffer, then drain
    apb(1'b1, sdl_pkg::OFS_CTRL, 32'h0);
    for (int i = 0; i < 17; i++) apb(1'b1, sdl_pkg::OFS_DATA, 32'h0000_F000 | 32'(i));
    apb(1'b0, sdl_pkg::OFS_STAT, 32'h0);
    check("stat full", rd, 32'h0000_0003);
    n = 0;
    do begin
      apb(1'b0, sdl_pkg::OFS_STAT, 32'h0);
      n++;
    end while (rd !== 32'h0000_0004 && n < 20000);
    check("stat drained", rd, 32'h0000_0004);
    check("last drained word", 32'(dac_code), 32'h010);
    // strobe held low: load on the sixteenth edge
    apb(1'b1, sdl_pkg::OFS_CTRL, 32'h0000_0002);
    // tying the strobe low is itself a falling edge: old word reloads
    wait_upd();
    check("tie-low strobe load", 32'(dac_code), 32'h010);
    apb(1'b1, sdl_pkg::OFS_DATA, 32'h0000_7FED);
    wait_upd();
    check("auto load", 32'(dac_code), 32'hFED);
    check("auto load inside frame", 32'(link.sync_n), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
